// *** verilog/pbcd_pkg.sv ***
// Constants shared by the window decoder and its helper modules.
package pbcd_pkg;

    // ********************************
    // Port types
    // ********************************
    typedef enum logic [1:0] {
        PBCD_PT_ENDPOINT = 2'h0,
        PBCD_PT_LEGACY = 2'h1,
        PBCD_PT_ROOT = 2'h3
    } pbcd_port_e;

    // ********************************
    // Window counts
    // ********************************
    localparam int PBCD_SLOTS_EP = 6;
    localparam int PBCD_SLOTS_RP = 2;
    localparam int PBCD_PF32_SLOT = 5;
    localparam logic [2:0] PBCD_ROM_ID = 3'h6;
    localparam logic [2:0] PBCD_NO_HIT = 3'h7;

    // ********************************
    // Size limits as log2 of bytes
    // ********************************
    localparam logic [5:0] PBCD_MIN_STD = 6'h07;
    localparam logic [5:0] PBCD_MIN_LEGACY = 6'h04;
    localparam logic [5:0] PBCD_MIN_IO = 6'h04;
    localparam logic [5:0] PBCD_MAX_32 = 6'h1f;
    localparam logic [5:0] PBCD_MAX_64 = 6'h3f;
    localparam logic [5:0] PBCD_ROM_MIN = 6'h0b;
    localparam logic [5:0] PBCD_ROM_MAX = 6'h20;
    localparam logic [5:0] PBCD_ROM_ADVISED = 6'h18;

    // ********************************
    // Legacy interrupt pin codes
    // ********************************
    localparam logic [7:0] PBCD_PIN_NONE = 8'h00;
    localparam logic [7:0] PBCD_PIN_INTA = 8'h01;

    // ********************************
    // Timing
    // ********************************
    localparam longint PBCD_CLK_HZ = 50000000;
    localparam longint PBCD_CPL_TIMEOUT_MS = 10;
    localparam int PBCD_CPL_TIMEOUT_CYCLES = int'((PBCD_CPL_TIMEOUT_MS * PBCD_CLK_HZ + 999) / 1000);

    // ********************************
    // Reset values
    // ********************************
    localparam logic [63:0] PBCD_ZERO64 = 64'h0;

endpackage

// *** verilog/pbcd_window_check.sv ***
// Legality check of one window slot against its port type.
`timescale 1ns/1ps
module pbcd_window_check #(
    parameter int SLOT = 0
) (
    input wire logic [1:0] portType,
    input wire logic enable,
    input wire logic isIo,
    input wire logic is64,
    input wire logic prefetch,
    input wire logic [5:0] sizeLog2,
    input wire logic upperHalf,
    output logic usable,
    output logic fault
);

    // ********************************
    // Combinational check
    // ********************************
    logic legacy;
    logic active;
    logic inRange;
    logic pairOk;
    logic sizeOk;
    logic typeOk;
    logic pfOk;
    int maxSlots;
    logic [5:0] minLog;
    logic [5:0] maxLog;

    always_comb begin
        legacy = (portType == pbcd_pkg::PBCD_PT_LEGACY);
        maxSlots = (portType == pbcd_pkg::PBCD_PT_ROOT) ? pbcd_pkg::PBCD_SLOTS_RP :
            pbcd_pkg::PBCD_SLOTS_EP;
        active = enable && !upperHalf;
        inRange = SLOT < maxSlots;
        pairOk = !is64 || (SLOT + 1 < maxSlots);
        if (isIo) begin
            minLog = pbcd_pkg::PBCD_MIN_IO;
        end else if (legacy) begin
            minLog = pbcd_pkg::PBCD_MIN_LEGACY;
        end else begin
            minLog = pbcd_pkg::PBCD_MIN_STD;
        end
        maxLog = is64 ? pbcd_pkg::PBCD_MAX_64 : pbcd_pkg::PBCD_MAX_32;
        sizeOk = (sizeLog2 >= minLog) && (sizeLog2 <= maxLog);
        typeOk = !isIo || (legacy && !is64);
        // On a standard endpoint a 32-bit prefetchable window is only allowed in the last slot; legacy and root ports allow it in any slot.
        pfOk = !((portType == pbcd_pkg::PBCD_PT_ENDPOINT) && !isIo && prefetch && !is64 &&
            (SLOT != pbcd_pkg::PBCD_PF32_SLOT));
        usable = active && inRange && pairOk && sizeOk && typeOk && pfOk;
        fault = active && !usable;
    end

endmodule

// *** verilog/pbcd_cpl_timer.sv ***
// Completion timeout timer for one outstanding request.
`timescale 1ns/1ps
module pbcd_cpl_timer #(
    parameter int CYCLES = pbcd_pkg::PBCD_CPL_TIMEOUT_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic reqSent,
    input wire logic cplDone,
    output logic timeout,
    output logic busy
);

    // ********************************
    // State
    // ********************************
    typedef enum logic [1:0] {
        PBCD_TM_IDLE = 2'h0,
        PBCD_TM_RUN = 2'h1,
        PBCD_TM_EXPIRED = 2'h3
    } pbcd_tm_e;

    localparam int CW = $clog2(CYCLES + 1);

    pbcd_tm_e state;
    pbcd_tm_e next_state;
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic next_timeout;

    always_comb begin
        next_state = state;
        next_count = count;
        next_timeout = 1'b0;
        case (state)
            PBCD_TM_IDLE: begin
                if (reqSent) begin
                    next_state = PBCD_TM_RUN;
                    next_count = CW'(CYCLES);
                end
            end
            PBCD_TM_RUN: begin
                if (cplDone) begin
                    next_state = PBCD_TM_IDLE;
                end else if (count == CW'(1)) begin
                    // Expiry lands no earlier than the full count after the request.
                    next_state = PBCD_TM_EXPIRED;
                    next_timeout = 1'b1;
                end else begin
                    next_count = count - CW'(1);
                end
            end
            PBCD_TM_EXPIRED: begin
                next_state = PBCD_TM_IDLE;
            end
            default: begin
                next_state = PBCD_TM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= PBCD_TM_IDLE;
            count <= '0;
            timeout <= 1'b0;
            busy <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            timeout <= next_timeout;
            busy <= (next_state == PBCD_TM_RUN);
        end
    end

endmodule

// *** verilog/pbcd_top.sv ***
// Base address window decoder with capability settings for a PCI Express port.
`timescale 1ns/1ps
module pbcd_top #(
    parameter int SLOTS = pbcd_pkg::PBCD_SLOTS_EP,
    parameter int CPL_TIMEOUT_CYCLES = pbcd_pkg::PBCD_CPL_TIMEOUT_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [1:0] portType,
    input wire logic [SLOTS-1:0] winEnable,
    input wire logic [SLOTS-1:0] winIsIo,
    input wire logic [SLOTS-1:0] winIs64,
    input wire logic [SLOTS-1:0] winPrefetch,
    input wire logic [SLOTS*6-1:0] winSizeLog2,
    input wire logic [SLOTS*32-1:0] winBase,
    input wire logic romEnable,
    input wire logic [5:0] romSizeLog2,
    input wire logic [31:0] romBase,
    input wire logic reqValid,
    input wire logic reqIsIo,
    input wire logic [63:0] reqAddr,
    input wire logic [7:0] intPinSel,
    input wire logic intxRequest,
    input wire logic msi64Enable,
    input wire logic msiRequest,
    input wire logic [63:0] msiAddrIn,
    input wire logic finiteCpl,
    input wire logic [11:0] cplSpace,
    input wire logic cplReqSent,
    input wire logic cplDone,
    output logic hitValid,
    output logic hitMiss,
    output logic [2:0] hitWindow,
    output logic [63:0] hitOffset,
    output logic hitPrefetch,
    output logic [SLOTS-1:0] winUsable,
    output logic [SLOTS-1:0] winFault,
    output logic romUsable,
    output logic romFault,
    output logic romOverAdvised,
    output logic [7:0] intPinCode,
    output logic intxMsg,
    output logic msiValid,
    output logic [63:0] msiAddrOut,
    output logic msiAddr64Cap,
    output logic cplCreditInfinite,
    output logic [11:0] cplCreditAdvert,
    output logic cplTimeout,
    output logic cplBusy
);

    // ********************************
    // Helpers
    // ********************************
    // Mask of the address bits at or above the window size.
    function automatic logic [63:0] sizeMask(input logic [5:0] log2Size);
        sizeMask = ~((64'h1 << log2Size) - 64'h1);
    endfunction

    // ********************************
    // Window legality
    // ********************************
    logic [SLOTS-1:0] usable;
    logic [SLOTS-1:0] fault;
    logic [SLOTS-1:0] upperHalf;

    genvar g;
    generate
        for (g = 0; g < SLOTS; g++) begin : gSlot
            if (g == 0) begin : gFirst
                assign upperHalf[g] = 1'b0;
            end else begin : gRest
                assign upperHalf[g] = usable[g-1] && winIs64[g-1];
            end
            pbcd_window_check #(
                .SLOT(g)
            ) uCheck (
                .portType(portType),
                .enable(winEnable[g]),
                .isIo(winIsIo[g]),
                .is64(winIs64[g]),
                .prefetch(winPrefetch[g]),
                .sizeLog2(winSizeLog2[g*6 +: 6]),
                .upperHalf(upperHalf[g]),
                .usable(usable[g]),
                .fault(fault[g])
            );
        end
    endgenerate

    // ********************************
    // ROM window legality
    // ********************************
    logic romOk;
    logic romBad;
    logic romBig;

    always_comb begin
        romOk = romEnable && (romSizeLog2 >= pbcd_pkg::PBCD_ROM_MIN) &&
            (romSizeLog2 <= pbcd_pkg::PBCD_ROM_MAX);
        romBad = romEnable && !romOk;
        romBig = romOk && (romSizeLog2 > pbcd_pkg::PBCD_ROM_ADVISED);
    end

    // ********************************
    // Address match
    // ********************************
    logic next_hitValid;
    logic next_hitMiss;
    logic [2:0] next_hitWindow;
    logic [63:0] next_hitOffset;
    logic next_hitPrefetch;

    always_comb begin
        logic found;
        logic [63:0] base;
        logic [63:0] mask;
        found = 1'b0;
        base = pbcd_pkg::PBCD_ZERO64;
        mask = pbcd_pkg::PBCD_ZERO64;
        next_hitValid = 1'b0;
        next_hitMiss = 1'b0;
        next_hitWindow = pbcd_pkg::PBCD_NO_HIT;
        next_hitOffset = pbcd_pkg::PBCD_ZERO64;
        next_hitPrefetch = 1'b0;
        if (reqValid) begin
            // The lowest slot wins; legal windows never overlap in a sane setup.
            for (int i = 0; i < SLOTS; i++) begin
                mask = sizeMask(winSizeLog2[i*6 +: 6]);
                base = {32'h0, winBase[i*32 +: 32]};
                if (winIs64[i] && (i + 1 < SLOTS)) begin
                    base[63:32] = winBase[(i+1)*32 +: 32];
                end
                if (!found && usable[i] && (winIsIo[i] == reqIsIo) &&
                    ((reqAddr & mask) == (base & mask))) begin
                    found = 1'b1;
                    next_hitWindow = 3'(i);
                    next_hitOffset = reqAddr & ~mask;
                    // Prefetch hint tells requesters they may merge and reread.
                    next_hitPrefetch = winPrefetch[i] && !winIsIo[i];
                end
            end
            mask = sizeMask(romSizeLog2);
            base = {32'h0, romBase};
            if (!found && romOk && !reqIsIo && ((reqAddr & mask) == (base & mask))) begin
                found = 1'b1;
                next_hitWindow = pbcd_pkg::PBCD_ROM_ID;
                next_hitOffset = reqAddr & ~mask;
            end
            next_hitValid = found;
            next_hitMiss = !found;
        end
    end

    // ********************************
    // Interrupt and credit settings
    // ********************************
    logic [7:0] next_intPinCode;
    logic next_intxMsg;
    logic next_msiValid;
    logic [63:0] next_msiAddrOut;
    logic [11:0] next_cplCreditAdvert;

    always_comb begin
        // Any pin code other than INTA is treated as none.
        next_intPinCode = (intPinSel == pbcd_pkg::PBCD_PIN_INTA) ? pbcd_pkg::PBCD_PIN_INTA :
            pbcd_pkg::PBCD_PIN_NONE;
        next_intxMsg = intxRequest && (next_intPinCode == pbcd_pkg::PBCD_PIN_INTA);
        next_msiValid = msiRequest;
        next_msiAddrOut = msi64Enable ? msiAddrIn : {32'h0, msiAddrIn[31:0]};
        // A zero credit field means infinite space to the link partner.
        next_cplCreditAdvert = finiteCpl ? cplSpace : 12'h0;
    end

    // ********************************
    // Completion timer
    // ********************************
    logic tmTimeout;
    logic tmBusy;

    pbcd_cpl_timer #(
        .CYCLES(CPL_TIMEOUT_CYCLES)
    ) uTimer (
        .clock(clock),
        .rst_n(rst_n),
        .reqSent(cplReqSent),
        .cplDone(cplDone),
        .timeout(tmTimeout),
        .busy(tmBusy)
    );

    // ********************************
    // Output registers
    // ********************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            hitValid <= 1'b0;
            hitMiss <= 1'b0;
            hitWindow <= pbcd_pkg::PBCD_NO_HIT;
            hitOffset <= pbcd_pkg::PBCD_ZERO64;
            hitPrefetch <= 1'b0;
            winUsable <= '0;
            winFault <= '0;
            romUsable <= 1'b0;
            romFault <= 1'b0;
            romOverAdvised <= 1'b0;
            intPinCode <= pbcd_pkg::PBCD_PIN_NONE;
            intxMsg <= 1'b0;
            msiValid <= 1'b0;
            msiAddrOut <= pbcd_pkg::PBCD_ZERO64;
            msiAddr64Cap <= 1'b0;
            cplCreditInfinite <= 1'b1;
            cplCreditAdvert <= 12'h0;
            cplTimeout <= 1'b0;
            cplBusy <= 1'b0;
        end else begin
            hitValid <= next_hitValid;
            hitMiss <= next_hitMiss;
            hitWindow <= next_hitWindow;
            hitOffset <= next_hitOffset;
            hitPrefetch <= next_hitPrefetch;
            winUsable <= usable;
            winFault <= fault;
            romUsable <= romOk;
            romFault <= romBad;
            romOverAdvised <= romBig;
            intPinCode <= next_intPinCode;
            intxMsg <= next_intxMsg;
            msiValid <= next_msiValid;
            msiAddrOut <= next_msiAddrOut;
            msiAddr64Cap <= msi64Enable;
            cplCreditInfinite <= !finiteCpl;
            cplCreditAdvert <= next_cplCreditAdvert;
            cplTimeout <= tmTimeout;
            cplBusy <= tmBusy;
        end
    end

endmodule

// *** sim/pbcd_chk.sv ***
// Concurrent checks on the ports of the window decoder.
`timescale 1ns/1ps
module pbcd_chk #(
    parameter int CPL_TIMEOUT_CYCLES = 20
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [1:0] portType,
    input wire logic reqValid,
    input wire logic reqIsIo,
    input wire logic hitValid,
    input wire logic hitMiss,
    input wire logic hitPrefetch,
    input wire logic [7:0] intPinSel,
    input wire logic intxRequest,
    input wire logic intxMsg,
    input wire logic msi64Enable,
    input wire logic msiRequest,
    input wire logic [63:0] msiAddrIn,
    input wire logic msiValid,
    input wire logic [63:0] msiAddrOut,
    input wire logic finiteCpl,
    input wire logic [11:0] cplSpace,
    input wire logic cplCreditInfinite,
    input wire logic [11:0] cplCreditAdvert,
    input wire logic cplReqSent,
    input wire logic cplTimeout
);
    // ********
    // Checks
    // ********
    logic [15:0] sinceReq;
    logic [15:0] next_sinceReq;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Cycles since the last start, so an early expiry shows as a small count.
    always_comb next_sinceReq = cplReqSent ? 16'h0 : sinceReq + 16'h1;
    always_ff @(posedge clock) sinceReq <= rst_n ? next_sinceReq : 16'h0;

    ans_once_a: assert property (reqValid |=> hitValid != hitMiss)
        else $error("Request not answered exactly once.");
    quiet_out_a: assert property (!reqValid |=> !hitValid && !hitMiss)
        else $error("Answer without a request.");
    io_pref_a: assert property (reqValid && reqIsIo |=> !hitPrefetch)
        else $error("I/O claim marked prefetchable.");
    io_legacy_a: assert property (reqValid && reqIsIo && portType != pbcd_pkg::PBCD_PT_LEGACY
        |=> hitMiss) else $error("I/O request claimed outside legacy mode.");
    intx_pin_a: assert property (intxRequest
        |=> intxMsg == ($past(intPinSel) == pbcd_pkg::PBCD_PIN_INTA))
        else $error("Legacy interrupt message wrong for pin setting.");
    msi_low_a: assert property (msiRequest && !msi64Enable
        |=> msiValid && msiAddrOut[63:32] == 32'h0) else $error("Short message address wrong.");
    msi_full_a: assert property (msiRequest && msi64Enable
        |=> msiValid && msiAddrOut == $past(msiAddrIn)) else $error("Long message address wrong.");
    cpl_credit_a: assert property ($past(rst_n) |-> cplCreditInfinite == !$past(finiteCpl)
        && cplCreditAdvert == ($past(finiteCpl) ? $past(cplSpace) : 12'h0))
        else $error("Completion credit advert wrong.");
    cpl_early_a: assert property (cplTimeout |-> sinceReq >= CPL_TIMEOUT_CYCLES)
        else $error("Completion timeout fired early.");

    cover property (hitValid && hitPrefetch);
    cover property (hitMiss);
    cover property (intxMsg);
    cover property (cplTimeout);
endmodule

// *** sim/pbcd_link_partner.sv ***
// Link partner model that issues memory and I/O requests toward the decoder.
`timescale 1ns/1ps
module pbcd_link_partner (
    input wire logic clock,
    output logic reqValid,
    output logic reqIsIo,
    output logic [63:0] reqAddr
);
    // ********
    // Driver
    // ********
    initial begin
        reqValid = 1'b0;
        reqIsIo = 1'b0;
        reqAddr = 64'h0;
    end
    // One request per call; calls in a row give back-to-back requests.
    task send(input logic io, input logic [63:0] a);
        @(negedge clock);
        reqValid = 1'b1;
        reqIsIo = io;
        reqAddr = a;
    endtask
    // Released lines invert every cycle so a stale address never decodes by luck.
    task idle(input int k);
        repeat (k) begin
            @(negedge clock);
            reqValid = 1'b0;
            reqIsIo = ~reqIsIo;
            reqAddr = ~reqAddr;
        end
    endtask
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the window decoder.
`timescale 1ns/1ps
module tb_top;
    // ********
    // Bench
    // ********
    localparam int CYC = 20;
    logic clock, rst_n, romEnable, reqValid, reqIsIo, intxRequest, msi64Enable, msiRequest;
    logic finiteCpl, cplReqSent, cplDone, hitValid, hitMiss, hitPrefetch, romUsable, romFault;
    logic romOverAdvised, intxMsg, msiValid, msiAddr64Cap, cplCreditInfinite, cplTimeout, cplBusy;
    logic [1:0] portType;
    logic [5:0] winEnable, winIsIo, winIs64, winPrefetch, winUsable, winFault, romSizeLog2;
    logic [35:0] winSizeLog2;
    logic [191:0] winBase;
    logic [31:0] romBase;
    logic [63:0] reqAddr, msiAddrIn, hitOffset, msiAddrOut, r;
    logic [7:0] intPinSel, intPinCode;
    logic [11:0] cplSpace, cplCreditAdvert;
    logic [2:0] hitWindow;
    logic [68:0] q[$];
    logic [68:0] e;
    logic [5:0] rs[6] = '{6'h0a, 6'h0b, 6'h18, 6'h19, 6'h20, 6'h21};
    int n_errors = 0;
    int samples_checked = 0;
    int n;

    pbcd_top #(.SLOTS(6), .CPL_TIMEOUT_CYCLES(CYC)) DUT (
        .clock, .rst_n, .portType, .winEnable, .winIsIo, .winIs64, .winPrefetch, .winSizeLog2,
        .winBase, .romEnable, .romSizeLog2, .romBase, .reqValid, .reqIsIo, .reqAddr, .intPinSel,
        .intxRequest, .msi64Enable, .msiRequest, .msiAddrIn, .finiteCpl, .cplSpace, .cplReqSent,
        .cplDone, .hitValid, .hitMiss, .hitWindow, .hitOffset, .hitPrefetch, .winUsable,
        .winFault, .romUsable, .romFault, .romOverAdvised, .intPinCode, .intxMsg, .msiValid,
        .msiAddrOut, .msiAddr64Cap, .cplCreditInfinite, .cplCreditAdvert, .cplTimeout, .cplBusy
    );
    pbcd_link_partner LP (.clock, .reqValid, .reqIsIo, .reqAddr);

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task summarize;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task fail(input string m);
        n_errors++;
        $display("MISMATCH %0t %s", $time, m);
    endtask
    task chk(input logic c, input string m);
        samples_checked++;
        if (c !== 1'b1) fail(m);
    endtask
    task step(input int k);
        repeat (k) @(negedge clock);
    endtask
    // Window 7 stands for a request that no window may claim.
    task req(input logic io, input logic [63:0] a, input logic [2:0] w, input logic [63:0] o,
             input logic pf);
        q.push_back({w != 3'h7, pf, w, o});
        LP.send(io, a);
    endtask

    always @(negedge clock) begin
        if (hitValid === 1'b1 || hitMiss === 1'b1) begin
            if (q.size() == 0) begin
                fail("answer without request");
            end else begin
                e = q.pop_front();
                samples_checked++;
                if ({hitValid, hitMiss, hitWindow} !== {e[68], ~e[68], e[66:64]} ||
                    (e[68] && {hitPrefetch, hitOffset} !== {e[67], e[63:0]})) fail("decode");
            end
        end
    end

    initial begin
        {rst_n, intxRequest, msi64Enable, msiRequest, finiteCpl, cplReqSent, cplDone} = '0;
        {portType, winEnable, winIsIo, winIs64, winPrefetch} = {2'h0, 6'h37, 6'h0, 6'h1, 6'h31};
        winSizeLog2 = {6'h1f, 6'h0c, 6'h0c, 6'h07, 6'h00, 6'h0c};
        winBase = {32'h8000_0000, 32'h3000_0000, 32'h2000_0000, 32'h1000_0000, 32'h1, 32'h8000_0000};
        {romEnable, romSizeLog2, romBase} = {1'b1, 6'h0b, 32'h4000_0000};
        {intPinSel, msiAddrIn, cplSpace} = '0;
        void'($urandom(32'he1db));
        r = {$urandom, $urandom};
        step(10);
        rst_n = 1'b1;
        LP.idle(2);
        chk(winUsable === 6'h25 && winFault === 6'h10, "endpoint slots");
        chk(romUsable === 1'b1 && romFault === 1'b0, "rom on");
        req(1'b0, {32'h1, 20'h80000, r[11:0]}, 3'h0, r[11:0], 1'b1);
        req(1'b0, {33'h1, r[30:0]}, 3'h5, r[30:0], 1'b1);
        req(1'b0, {57'h200000, r[6:0]}, 3'h2, r[6:0], 1'b0);
        req(1'b1, 64'h1000_0000, 3'h7, 64'h0, 1'b0);
        req(1'b0, 64'h2000_0000, 3'h7, 64'h0, 1'b0);
        req(1'b0, 64'h3000_0000, 3'h7, 64'h0, 1'b0);
        req(1'b0, {53'h80000, r[10:0]}, 3'h6, r[10:0], 1'b0);
        req(1'b0, 64'h1_1000_0000, 3'h7, 64'h0, 1'b0);
        req(1'b0, 64'h1_8000_1000, 3'h7, 64'h0, 1'b0);
        LP.idle(2);
        for (int i = 0; i < 6; i++) begin
            romSizeLog2 = rs[i];
            step(2);
            chk(romFault === (rs[i] < 6'h0b || rs[i] > 6'h20), "rom size");
            chk(romFault === 1'b1 || romOverAdvised === (rs[i] > 6'h18), "rom advice");
        end
        {romSizeLog2, portType, winIsIo, winEnable} = {6'h0b, 2'h1, 6'h04, 6'h3d};
        romEnable = 1'b0;
        winSizeLog2[23:12] = {6'h04, 6'h04};
        LP.idle(2);
        chk(winUsable === 6'h3d && winFault === 6'h00, "legacy slots");
        chk(romUsable === 1'b0 && romFault === 1'b0, "rom off");
        req(1'b1, {60'h1000000, r[3:0]}, 3'h2, r[3:0], 1'b0);
        req(1'b0, 64'h1000_0000, 3'h7, 64'h0, 1'b0);
        req(1'b0, {60'h2000000, r[3:0]}, 3'h3, r[3:0], 1'b0);
        req(1'b0, {52'h30000, r[11:0]}, 3'h4, r[11:0], 1'b1);
        req(1'b0, 64'h4000_0000, 3'h7, 64'h0, 1'b0);
        // Let the last request be taken before the port type moves under it.
        LP.idle(1);
        portType = 2'h0;
        LP.idle(2);
        chk(winFault === 6'h1c, "small windows");
        req(1'b1, 64'h1000_0000, 3'h7, 64'h0, 1'b0);
        LP.idle(1);
        {portType, winIsIo} = {2'h3, 6'h0};
        {romEnable, romBase, winPrefetch} = {1'b1, 32'h0900_0000, 6'h30};
        winSizeLog2[17:12] = 6'h07;
        LP.idle(2);
        chk(winUsable === 6'h01, "root slots");
        req(1'b0, {32'h1, 20'h80000, r[23:12]}, 3'h0, r[23:12], 1'b0);
        req(1'b0, 64'h1000_0000, 3'h7, 64'h0, 1'b0);
        req(1'b0, 64'h8000_0000, 3'h7, 64'h0, 1'b0);
        req(1'b0, {53'h12000, r[10:0]}, 3'h6, r[10:0], 1'b0);
        LP.idle(2);
        for (int i = 0; i < 3; i++) begin
            {intPinSel, msi64Enable, intxRequest, msiRequest} = {i[7:0], i[0], 2'h3};
            msiAddrIn = {$urandom, $urandom};
            step(1);
            {intxRequest, msiRequest} = 2'h0;
            chk(intxMsg === (i == 1) && intPinCode === {7'h0, i == 1}, "pin");
            chk(msiValid === 1'b1 && msiAddr64Cap === i[0], "msi");
            chk(msiAddrOut === (i[0] ? msiAddrIn : {32'h0, msiAddrIn[31:0]}), "msi addr");
            step(1);
            chk(intxMsg === 1'b0 && msiValid === 1'b0, "pulse");
        end
        {finiteCpl, cplSpace} = {1'b1, r[43:32]};
        step(2);
        chk(cplCreditInfinite === 1'b0 && cplCreditAdvert === r[43:32], "finite");
        finiteCpl = 1'b0;
        step(2);
        chk(cplCreditInfinite === 1'b1 && cplCreditAdvert === 12'h0, "infinite");
        cplReqSent = 1'b1;
        step(1);
        cplReqSent = 1'b0;
        n = 0;
        while (cplTimeout !== 1'b1 && n < 60) begin
            step(1);
            n++;
        end
        chk(n >= CYC && n <= CYC + 3, "expiry");
        step(2);
        cplReqSent = 1'b1;
        step(1);
        cplReqSent = 1'b0;
        step(5);
        chk(cplBusy === 1'b1, "busy");
        cplDone = 1'b1;
        step(1);
        cplDone = 1'b0;
        n = 0;
        repeat (40) begin
            step(1);
            if (cplTimeout === 1'b1) n++;
        end
        chk(n == 0 && cplBusy === 1'b0, "cancel");
        chk(q.size() == 0, "unanswered");
        summarize();
    end
endmodule

bind pbcd_top pbcd_chk #(.CPL_TIMEOUT_CYCLES(CPL_TIMEOUT_CYCLES)) chk (
    .clock, .rst_n, .portType, .reqValid, .reqIsIo, .hitValid, .hitMiss, .hitPrefetch,
    .intPinSel, .intxRequest, .intxMsg, .msi64Enable, .msiRequest, .msiAddrIn, .msiValid,
    .msiAddrOut, .finiteCpl, .cplSpace, .cplCreditInfinite, .cplCreditAdvert, .cplReqSent,
    .cplTimeout
);
